// *** test_tpc_timer.sv ***
// Testbench: random and corner scenarios for the timer
`timescale 1ns/100ps
`default_nettype none
module test_tpc_timer;
    import tpc_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        lvl = 1'b0;
    logic [15:0] rdata;
    logic        timer_in, timer_out, complement_output, timer_irq;
    int          n_mismatch = 0;
    int          check_count = 0;
    always #5 clk = ~clk;
    tpc_timer u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .timer_in(timer_in),
        .timer_out(timer_out), .complement_output(complement_output),
        .timer_irq(timer_irq));
    tpc_pin_model u_pin (.lvl(lvl), .timer_in(timer_in));
    // ------
    // Tasks
    // ------
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic wirq(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (timer_irq !== 1'b1 && n < 3000);
        if (n >= 3000) cmp(16'h0001, 16'h0000, "no interrupt");
    endtask
    task automatic pulse(output int n);
        n = 0;
        lvl <= 1'b1;
        for (int c = 0; c < 20; c++) begin
            @(posedge clk);
            if (c == 3) lvl <= 1'b0;
            #1;
            n += (timer_irq === 1'b1);
        end
    endtask
    task automatic cfg(input logic [15:0] c1, c0, st, rl, mt);
        wreg(TPC_OFF_CTL1, c1 & 16'h7fff);
        wreg(TPC_OFF_CTL0, c0);
        wreg(TPC_OFF_CNT, st);
        wreg(TPC_OFF_RELOAD, rl);
        wreg(TPC_OFF_MATCH, mt);
        wreg(TPC_OFF_CTL1, c1);
    endtask
    task automatic tfirst(input logic [15:0] c1, st, rl, output int n);
        cfg(c1, 16'h0000, st, rl, 16'h0002);
        wirq(n);
    endtask
    function automatic logic [15:0] c1f(input logic [2:0] md, ps,
                                        input logic pl, oe);
        return {1'b1, 5'h00, oe, pl, 1'b0, ps, 1'b0, md};
    endfunction
    function automatic logic [15:0] hi_exp(input logic pl,
        input logic [15:0] r, m, input logic [2:0] ps);
        return (pl ? m : r - m) << ps;
    endfunction
    // ------
    // Scenarios
    // ------
    initial begin
        int          t1, t2, k, a, b;
        logic [15:0] v, w, rl, mt, e;
        logic [2:0]  pre, md;
        logic [1:0]  sel;
        logic        pol;
        void'($urandom(90));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rreg(TPC_OFF_CNT, v);
        cmp(v, TPC_RST_CNT, "count reset");
        rreg(TPC_OFF_RELOAD, v);
        cmp(v, TPC_RST_RELOAD, "reload reset");
        for (int i = 6; i < 16; i += 3) begin
            wreg(4'(i), 16'($urandom));
            rreg(4'(i), v);
            cmp(v, 16'h0000, "unmapped");
        end
        for (int i = 0; i < 6; i++) begin
            rl = 16'(20 + $urandom_range(30));
            mt = 16'(6 + $urandom_range(rl - 12));
            pol = 1'($urandom);
            pre = 3'($urandom_range(1));
            k = (i < 3) ? 0 : 4;
            md = (i < 3) ? TPC_MODE_PWM1 : TPC_MODE_PWM2;
            cfg(c1f(md, pre, pol, 1'b1), 16'(k), 16'h0001, rl, mt);
            wirq(t1);
            wirq(t1);
            cnt_hi(rl << pre, a, b);
            e = hi_exp(pol, rl, mt, pre);
            cmp(16'(a), e - 16'(k), "pwm high");
            cmp(16'(b), k ? (rl << pre) - e - 16'(k) : 0, "comp");
        end
        tfirst(c1f(TPC_MODE_PWM1, 3'h0, 1'b0, 1'b1), 16'd1, 16'd40, t1);
        wirq(t2);
        cmp(16'(t2), 16'd40, "period");
        tfirst(c1f(TPC_MODE_PWM1, 3'h0, 1'b0, 1'b1), 16'd31, 16'd40, t2);
        cmp(16'(t1 - t2), 16'd30, "first pass");
        tfirst(c1f(TPC_MODE_CMP, 3'h0, 1'b0, 1'b1), 16'h0001, 16'h0010, t1);
        tfirst(c1f(TPC_MODE_CMP, 3'h0, 1'b0, 1'b1), 16'hffe0, 16'h0010, t2);
        cmp(16'(t2 - t1), 16'h0021, "wrap");
        rreg(TPC_OFF_CNT, v);
        cmp(16'(v > 16'h0010 && v < 16'h0018), 16'h1, "no reset");
        lvl <= 1'b1;
        tfirst(c1f(TPC_MODE_GATED, 3'h0, 1'b1, 1'b0), 16'd1, 16'd40, t1);
        tfirst(c1f(TPC_MODE_GATED, 3'h0, 1'b1, 1'b0), 16'd21, 16'd40, t2);
        cmp(16'(t1 - t2), 16'd20, "gated first pass");
        lvl <= 1'b0;
        cfg(c1f(TPC_MODE_GATED, 3'h0, 1'b1, 1'b0), 16'h0, 16'h5, 16'd40, 0);
        repeat (30) @(posedge clk);
        rreg(TPC_OFF_CNT, v);
        cmp(v, 16'h0005, "gate paused");
        lvl <= 1'b1;
        repeat (10) @(posedge clk);
        lvl <= 1'b0;
        wirq(k);
        cmp(16'(k < 8), 16'h1, "deassert irq");
        for (int i = 0; i < 3; i++) begin
            md = (i == 0) ? TPC_MODE_CAP : TPC_MODE_CAPRS;
            sel = (i == 2) ? TPC_ISEL_RLD : TPC_ISEL_BOTH;
            cfg(c1f(md, 3'h0, 1'b0, 1'b0), {6'h0, sel, 8'h0}, 1, 200, 0);
            repeat (30) @(posedge clk);
            pulse(k);
            cmp(16'(k), (i == 2) ? 16'h0 : 16'h1, "capture irq");
            rreg(TPC_OFF_MATCH, v);
            cmp(16'(v > 16'd28 && v < 16'd48), 16'h1, "captured");
            rreg(TPC_OFF_CNT, w);
            cmp(16'(i == 0 ? w > v : w < v), 16'h1, "after");
            if (i == 1) begin
                rreg(TPC_OFF_STAT, w);
                cmp(w & 16'h1, 16'h1, "flag set");
                wirq(k);
                rreg(TPC_OFF_STAT, w);
                cmp(w & 16'h1, 16'h0, "flag clear");
            end
        end
        cfg(c1f(TPC_MODE_CAPCM, 3'h0, 1'b0, 1'b0), 0, 1, 200, 0);
        repeat (20) @(posedge clk);
        rreg(TPC_OFF_CNT, v);
        cmp(v, 16'h0001, "held");
        pulse(k);
        rreg(TPC_OFF_CNT, v);
        cmp(16'(v > 16'h0008), 16'h1, "started");
        close_out();
    end
    task automatic cnt_hi(input logic [15:0] p, output int a, output int b);
        a = 0;
        b = 0;
        repeat (p) begin
            @(posedge clk);
            #1;
            a += (timer_out === 1'b1);
            b += (complement_output === 1'b1);
        end
    endtask
    // Whole run is well under 100k cycles; this only cuts a hang
    initial begin
        #1_000_000;
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire

// *** tpc_deadband.sv ***
// Rising-edge delay of one PWM output by a programmable count
`timescale 1ns/100ps
`default_nettype none
module tpc_deadband (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] delay,
    input  wire logic       din,
    output var  logic       dout
);
    logic [7:0] cnt_q;

    // Low goes through at once; high waits delay cycles of steady input
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 8'h00;
            dout  <= 1'b0;
        end else if (!din) begin
            cnt_q <= 8'h00;
            dout  <= 1'b0;
        end else if (cnt_q >= delay) begin
            dout  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** tpc_pin_model.sv ***
// Pin-side model: drives the timer input pin
`timescale 1ns/100ps
`default_nettype none
module tpc_pin_model #(
    parameter int SKEW = 3
) (
    input  wire logic lvl,
    output var  logic timer_in
);
    // ------
    // Pin drive
    // ------
    // Skew keeps pin changes away from the clock edge, like a real pin
    initial timer_in = 1'b0;
    always @(lvl) timer_in <= #(SKEW) lvl;
endmodule
`default_nettype wire

// *** tpc_pkg.sv ***
// Package: register map, field layout, reset values and mode codes of the timer
package tpc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] TPC_OFF_CNT    = 4'h0;
    localparam logic [3:0] TPC_OFF_RELOAD = 4'h1;
    localparam logic [3:0] TPC_OFF_MATCH  = 4'h2;
    localparam logic [3:0] TPC_OFF_CTL0   = 4'h3;
    localparam logic [3:0] TPC_OFF_CTL1   = 4'h4;
    localparam logic [3:0] TPC_OFF_STAT   = 4'h5;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TPC_CTL0_DEADBAND_DELAY_FIELD_LSB = 0;   // deadband_delay_field [7:0]
    localparam int TPC_CTL0_ISEL_LSB = 8;   // interrupt_source_select [9:8]
    localparam int TPC_CTL1_MODE_LSB = 0;   // mode [2:0]
    localparam int TPC_CTL1_PRE_LSB  = 4;   // prescale exponent [6:4]
    localparam int TPC_CTL1_POL_BIT  = 8;   // output_polarity_select
    localparam int TPC_CTL1_OEN_BIT  = 9;   // output function enable
    localparam int TPC_CTL1_EN_BIT   = 15;  // timer enable
    // ------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------
    localparam logic [15:0] TPC_RST_CNT    = 16'h0001;
    localparam logic [15:0] TPC_RST_RELOAD = 16'hffff;
    localparam logic [15:0] TPC_RST_MATCH  = 16'h0000;
    localparam logic [15:0] TPC_CNT_START  = 16'h0001;
    localparam logic [15:0] TPC_CNT_WRAP   = 16'h0000;
    localparam logic [7:0]  TPC_DB_MAX     = 8'h80;
    // ------------------------------------------------------------
    // Modes and interrupt source choices
    // ------------------------------------------------------------
    localparam logic [2:0] TPC_MODE_PWM1  = 3'h0;
    localparam logic [2:0] TPC_MODE_PWM2  = 3'h1;
    localparam logic [2:0] TPC_MODE_CAP   = 3'h2;
    localparam logic [2:0] TPC_MODE_CAPRS = 3'h3;
    localparam logic [2:0] TPC_MODE_CAPCM = 3'h4;
    localparam logic [2:0] TPC_MODE_CMP   = 3'h5;
    localparam logic [2:0] TPC_MODE_GATED = 3'h6;
    localparam logic [1:0] TPC_ISEL_BOTH  = 2'h0;
    localparam logic [1:0] TPC_ISEL_INPUT = 2'h1;
    localparam logic [1:0] TPC_ISEL_RLD   = 2'h2;
endpackage

// *** tpc_sync.sv ***
// Two-flop synchroniser for a pin input
`timescale 1ns/100ps
`default_nettype none
module tpc_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output var  logic dout
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** tpc_timer.sv ***
// 16-bit timer: PWM, capture, compare and gated modes with deadband
`timescale 1ns/100ps
`default_nettype none
module tpc_timer
    import tpc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output var  logic [15:0] rdata,
    input  wire logic        timer_in,
    output var  logic        timer_out,
    output var  logic        complement_output,
    output var  logic        timer_irq
);
    import tpc_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] cnt_q;
    logic [15:0] reload_q;
    logic [15:0] match_q;
    logic [7:0]  deadband_delay_field;
    logic [1:0]  interrupt_source_select;
    logic [2:0]  mode_q;
    logic [2:0]  pre_sel_q;
    logic        output_polarity_select;
    logic        oen_q;
    logic        en_q;
    logic        capture_interrupt_flag;
    logic        out_q;
    logic        armed_q;
    logic        in_prev_q;
    logic [7:0]  pre_q;
    logic        irq_q;

    logic        in_s;
    logic        tick;
    logic        in_act;
    logic        edge_cap;
    logic        gate_off;
    logic        at_reload;
    logic        at_match;
    logic        is_pwm;
    logic        is_cap;
    logic        cap_ev;
    logic        rld_ev;
    logic        irq_cap;
    logic        irq_rld;
    logic        wr_cnt;
    logic        db_a_in;
    logic        db_b_in;
    logic        db_a;
    logic        db_b;

    // ------------------------------------------------------------
    // Pin input and event detection
    // ------------------------------------------------------------
    tpc_sync u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (timer_in),
        .dout (in_s)
    );

    // Active level equals polarity bit; previous value kept for edges
    assign in_act   = (in_s == output_polarity_select);
    assign edge_cap = en_q && in_act && (in_prev_q != output_polarity_select);
    assign gate_off = en_q && !in_act && (in_prev_q == output_polarity_select);

    always_ff @(posedge clk) begin
        if (rst) begin
            in_prev_q <= 1'b0;
        end else begin
            in_prev_q <= in_s;
        end
    end

    // ------------------------------------------------------------
    // Prescaler: divide by 2**pre_sel
    // ------------------------------------------------------------
    assign tick = en_q && ((pre_q | ~((8'h01 << pre_sel_q) - 8'h01)) == 8'hff);

    always_ff @(posedge clk) begin
        if (rst || !en_q) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= pre_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    assign is_pwm    = (mode_q == TPC_MODE_PWM1) || (mode_q == TPC_MODE_PWM2);
    assign is_cap    = (mode_q == TPC_MODE_CAP) || (mode_q == TPC_MODE_CAPRS)
                    || (mode_q == TPC_MODE_CAPCM);
    assign at_reload = tick && (cnt_q == reload_q);
    assign at_match  = tick && (cnt_q == match_q);
    // Capture/compare ignores its first edge, which only starts counting
    assign cap_ev    = is_cap && edge_cap
                    && !(mode_q == TPC_MODE_CAPCM && !armed_q);
    assign rld_ev    = at_reload && (mode_q != TPC_MODE_CMP)
                    && !(mode_q == TPC_MODE_GATED && !in_act)
                    && !(mode_q == TPC_MODE_CAPCM && !armed_q);
    assign wr_cnt    = wr && (addr == TPC_OFF_CNT);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= TPC_RST_CNT;
        end else if (wr_cnt) begin
            cnt_q <= wdata;
        end else if (cap_ev && mode_q != TPC_MODE_CAP) begin
            cnt_q <= TPC_CNT_START;
        end else if (rld_ev && mode_q != TPC_MODE_CAP) begin
            cnt_q <= TPC_CNT_START;
        end else if (tick) begin
            case (mode_q)
                TPC_MODE_CAPCM: begin
                    if (armed_q) cnt_q <= cnt_q + 16'h0001;
                end
                TPC_MODE_GATED: begin
                    if (in_act) cnt_q <= cnt_q + 16'h0001;
                end
                default: begin
                    // Natural 16-bit overflow gives FFFF -> 0000
                    cnt_q <= cnt_q + 16'h0001;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !en_q) begin
            armed_q <= 1'b0;
        end else if (mode_q == TPC_MODE_CAPCM && edge_cap) begin
            armed_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Timer output
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (!en_q) begin
            out_q <= output_polarity_select;
        end else if (is_pwm && at_reload) begin
            out_q <= output_polarity_select;
        end else if (is_pwm && at_match) begin
            out_q <= !output_polarity_select;
        end else if (is_cap && rld_ev) begin
            out_q <= !out_q;
        end else if (mode_q == TPC_MODE_CMP && at_reload) begin
            out_q <= !out_q;
        end else if (mode_q == TPC_MODE_GATED && rld_ev) begin
            out_q <= !out_q;
        end
    end

    // Deadband applies only in dual mode
    assign db_a_in = out_q;
    assign db_b_in = !out_q;

    tpc_deadband u_db_a (
        .clk   (clk),
        .rst   (rst),
        .delay ((mode_q == TPC_MODE_PWM2) ? deadband_delay_field : 8'h00),
        .din   (db_a_in),
        .dout  (db_a)
    );

    tpc_deadband u_db_b (
        .clk   (clk),
        .rst   (rst),
        .delay (deadband_delay_field),
        .din   (db_b_in),
        .dout  (db_b)
    );

    // Outputs low unless the output function is enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_out         <= 1'b0;
            complement_output <= 1'b0;
        end else begin
            timer_out         <= oen_q && db_a;
            complement_output <= oen_q && (mode_q == TPC_MODE_PWM2) && db_b;
        end
    end

    // ------------------------------------------------------------
    // Interrupt and capture flag
    // ------------------------------------------------------------
    assign irq_cap = (cap_ev || (mode_q == TPC_MODE_GATED && gate_off))
                  && (interrupt_source_select != TPC_ISEL_RLD);
    assign irq_rld = (rld_ev || (mode_q == TPC_MODE_CAP && at_reload)
                   || (mode_q == TPC_MODE_CMP && at_reload))
                  && (is_pwm || interrupt_source_select != TPC_ISEL_INPUT);

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_cap || irq_rld;
        end
    end
    assign timer_irq = irq_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            capture_interrupt_flag <= 1'b0;
        end else if (irq_cap) begin
            capture_interrupt_flag <= 1'b1;
        end else if (irq_rld) begin
            capture_interrupt_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Match / capture register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            match_q <= TPC_RST_MATCH;
        end else if (cap_ev) begin
            match_q <= cnt_q;
        end else if (wr && addr == TPC_OFF_MATCH) begin
            match_q <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            reload_q                <= TPC_RST_RELOAD;
            deadband_delay_field    <= 8'h00;
            interrupt_source_select <= TPC_ISEL_BOTH;
            mode_q                  <= TPC_MODE_PWM1;
            pre_sel_q               <= 3'h0;
            output_polarity_select  <= 1'b0;
            oen_q                   <= 1'b0;
            en_q                    <= 1'b0;
        end else if (wr) begin
            if (addr == TPC_OFF_RELOAD) begin
                reload_q <= wdata;
            end else if (addr == TPC_OFF_CTL0) begin
                // Deadband saturates at its documented maximum
                deadband_delay_field <=
                    (wdata[TPC_CTL0_DEADBAND_DELAY_FIELD_LSB +: 8] > TPC_DB_MAX) ?
                    TPC_DB_MAX : wdata[TPC_CTL0_DEADBAND_DELAY_FIELD_LSB +: 8];
                interrupt_source_select <= wdata[TPC_CTL0_ISEL_LSB +: 2];
            end else if (addr == TPC_OFF_CTL1) begin
                mode_q                 <= wdata[TPC_CTL1_MODE_LSB +: 3];
                pre_sel_q              <= wdata[TPC_CTL1_PRE_LSB +: 3];
                output_polarity_select <= wdata[TPC_CTL1_POL_BIT];
                oen_q                  <= wdata[TPC_CTL1_OEN_BIT];
                en_q                   <= wdata[TPC_CTL1_EN_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            if (addr == TPC_OFF_CNT) begin
                rdata <= cnt_q;
            end else if (addr == TPC_OFF_RELOAD) begin
                rdata <= reload_q;
            end else if (addr == TPC_OFF_MATCH) begin
                rdata <= match_q;
            end else if (addr == TPC_OFF_CTL0) begin
                rdata <= {6'h00, interrupt_source_select, deadband_delay_field};
            end else if (addr == TPC_OFF_CTL1) begin
                rdata <= {en_q, 5'h00, oen_q, output_polarity_select,
                          1'b0, pre_sel_q, 1'b0, mode_q};
            end else if (addr == TPC_OFF_STAT) begin
                rdata <= {13'h0000, armed_q, in_s, capture_interrupt_flag};
            end else begin
                rdata <= 16'h0000;
            end
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// *** tpc_timer_monitor.sv ***
// Checker: port-level relations of the timer, bound into tpc_timer
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_monitor
    import tpc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        timer_in,
    input wire logic        timer_out,
    input wire logic        complement_output,
    input wire logic        timer_irq
);
    logic [15:0] rld_q, mat_q, ctl0_q, ctl1_q, gap_q, hi_q;
    logic [2:0]  quiet_q;
    logic [1:0]  nirq_q;
    logic [2:0]  mode;
    logic        calm;
    assign mode = ctl1_q[2:0];
    assign calm = quiet_q == 3'h7;
    // ------
    // Shadow of settings; any write restarts the watch
    // ------
    always_ff @(posedge clk) begin
        if (rst) begin
            rld_q  <= TPC_RST_RELOAD;
            mat_q  <= TPC_RST_MATCH;
            ctl0_q <= 16'h0000;
            ctl1_q <= 16'h0000;
        end else if (wr) begin
            if (addr == TPC_OFF_RELOAD) rld_q <= wdata;
            if (addr == TPC_OFF_MATCH) mat_q <= wdata;
            if (addr == TPC_OFF_CTL0) ctl0_q <= wdata;
            if (addr == TPC_OFF_CTL1) ctl1_q <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (rst || wr) begin
            quiet_q <= 3'h0;
            nirq_q  <= 2'h0;
        end else begin
            quiet_q <= calm ? quiet_q : quiet_q + 3'h1;
            nirq_q  <= (timer_irq && nirq_q != 2'h3) ? nirq_q + 2'h1 : nirq_q;
        end
    end
    always_ff @(posedge clk) begin
        gap_q <= timer_irq ? 16'h0001 : gap_q + 16'h0001;
        hi_q  <= timer_out ? hi_q + 16'h0001 : 16'h0000;
    end
    // ------
    // Assertions
    // ------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside its slot");
    AST_UNMAPPED: assert property (rd && addr > TPC_OFF_STAT
        |=> rdata == 16'h0000) else $error("unmapped read not zero");
    AST_SINGLE_NO_COMP: assert property (
        calm && mode != TPC_MODE_PWM2 |-> !complement_output)
        else $error("complement active outside dual mode");
    AST_OUT_OFF_LOW: assert property (
        calm && !ctl1_q[TPC_CTL1_OEN_BIT] |-> !timer_out)
        else $error("output driven while disabled");
    AST_IDLE_QUIET: assert property (
        calm && !ctl1_q[TPC_CTL1_EN_BIT] |-> !timer_irq)
        else $error("interrupt while timer off");
    AST_DB_GAP: assert property (
        calm && mode == TPC_MODE_PWM2 && ctl0_q[7:0] != 8'h00
        |-> !(timer_out && complement_output))
        else $error("both outputs high");
    AST_DB_HOLD: assert property (
        calm && mode == TPC_MODE_PWM2 && ctl0_q[7:0] == 8'h04
        && $fell(complement_output) |-> !timer_out [*3])
        else $error("rising edge not delayed");
    AST_PWM_PERIOD: assert property (
        timer_irq && mode <= TPC_MODE_PWM2 && nirq_q != 2'h0
        |-> gap_q == rld_q << ctl1_q[6:4])
        else $error("pwm period wrong");
    AST_PWM_HIGH: assert property (
        $fell(timer_out) && mode == TPC_MODE_PWM1 && nirq_q[1]
        |-> hi_q == (ctl1_q[8] ? mat_q : rld_q - mat_q) << ctl1_q[6:4])
        else $error("pwm high time wrong");
    AST_CMP_TOGGLE: assert property (
        calm && mode == TPC_MODE_CMP && ctl1_q[TPC_CTL1_OEN_BIT]
        && timer_irq |-> ##2 timer_out != $past(timer_out))
        else $error("compare output did not toggle");
endmodule
bind tpc_timer tpc_timer_monitor u_mon (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_in(timer_in), .timer_out(timer_out),
    .complement_output(complement_output), .timer_irq(timer_irq));
`default_nettype wire
